// file: bench/adcrc_capture_model.sv
`timescale 1ns/1ps
`include "adcrc_defs.svh"

module adcrc_capture_model (
    // Converter pins
    input  wire logic                     strobe_i,
    input  wire logic [`ADCRC_DATA_W-1:0] data_i,
    input  wire logic                     msb_n_i,
    input  wire logic                     flag_i,
    // Bench control
    input  wire logic                     stall_i,
    // Capture results
    output logic                          capture_ready_o,
    output adcrc_pkg::adcrc_result_type   new_o,
    output adcrc_pkg::adcrc_result_type   prev_o,
    output logic [`ADCRC_DATA_W-1:0]      twos_o,
    output logic [1:0]                    range_o,
    output int                            count_o
);
    assign capture_ready_o = !stall_i;
    initial begin
        count_o = 0;
        prev_o = '0;
    end
    always @(posedge strobe_i) begin
        new_o <= {flag_i, data_i};
        count_o <= count_o + 1;
    end
    always @(negedge strobe_i) begin
        prev_o <= {flag_i, data_i};
    end
    assign twos_o = {msb_n_i, data_i[`ADCRC_DATA_W-2:0]};
    assign range_o = {new_o.out_of_range & new_o.code[11], new_o.out_of_range & ~new_o.code[11]};
endmodule

// file: bench/adcrc_props.sv
`timescale 1ns/1ps
`include "adcrc_defs.svh"

module adcrc_props #(
    parameter int CONV_CYCLES = 4,
    parameter int HIGH_CYCLES = 2,
    parameter int LOW_CYCLES  = 2,
    parameter int BUF_DEPTH   = 2
) (
    // Clock and reset
    input wire logic                              sys_clk_i,
    input wire logic                              reset_i,
    // Design inputs
    input wire logic                              conversion_start_input_i,
    input wire logic signed [`ADCRC_LEVEL_W-1:0]  analog_level_i,
    input wire logic                              capture_ready_i,
    // Design outputs
    input wire logic [`ADCRC_DATA_W-1:0]          data_o,
    input wire logic                              data_msb_n_o,
    input wire logic                              out_of_range_flag_o,
    input wire logic                              conversion_done_strobe_o,
    input wire logic                              acquiring_o,
    input wire logic                              start_ready_o
);
    logic [7:0] hi_cnt_r;
    logic [7:0] lo_cnt_r;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) hi_cnt_r <= 8'h00;
        else hi_cnt_r <= conversion_done_strobe_o ? hi_cnt_r + 8'h01 : 8'h00;
    end

    // Low time saturates so an idle stretch always counts as long enough.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) lo_cnt_r <= 8'hFF;
        else if (conversion_done_strobe_o) lo_cnt_r <= 8'h00;
        else if (lo_cnt_r != 8'hFF) lo_cnt_r <= lo_cnt_r + 8'h01;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_word_shown;
        $changed(data_o) || $changed(out_of_range_flag_o);
    endsequence
    sequence s_strobe_end;
        $fell(conversion_done_strobe_o);
    endsequence

    property p_msb_pair;
        data_msb_n_o == ~data_o[`ADCRC_DATA_W-1];
    endproperty
    property p_sat_high;
        out_of_range_flag_o && data_o[`ADCRC_DATA_W-1] |-> data_o == `ADCRC_CODE_MAX;
    endproperty
    property p_sat_low;
        out_of_range_flag_o && !data_o[`ADCRC_DATA_W-1] |-> data_o == `ADCRC_CODE_MIN;
    endproperty
    property p_hold_high;
        conversion_done_strobe_o |-> $stable(data_o) && $stable(out_of_range_flag_o);
    endproperty
    property p_announce;
        s_word_shown |=> $rose(conversion_done_strobe_o);
    endproperty
    property p_high_width;
        s_strobe_end |-> hi_cnt_r == 8'(HIGH_CYCLES);
    endproperty
    property p_low_gap;
        $rose(conversion_done_strobe_o) |-> lo_cnt_r >= 8'(LOW_CYCLES);
    endproperty
    property p_acquire;
        s_strobe_end |-> ##[0:3] (acquiring_o || !start_ready_o);
    endproperty

    a_msb_pair:   assert property (p_msb_pair) else $error("msb pair differs");
    a_sat_high:   assert property (p_sat_high) else $error("high not saturated");
    a_sat_low:    assert property (p_sat_low) else $error("low not saturated");
    a_hold_high:  assert property (p_hold_high) else $error("word moved in strobe");
    a_announce:   assert property (p_announce) else $error("word without strobe");
    a_high_width: assert property (p_high_width) else $error("strobe width off");
    a_low_gap:    assert property (p_low_gap) else $error("strobe gap short");
    a_acquire:    assert property (p_acquire) else $error("no acquire");
endmodule

bind adcrc_top adcrc_props #(
    .CONV_CYCLES(CONV_CYCLES),
    .HIGH_CYCLES(HIGH_CYCLES),
    .LOW_CYCLES (LOW_CYCLES),
    .BUF_DEPTH  (BUF_DEPTH)
) i_adcrc_props (
    .sys_clk_i               (sys_clk_i),
    .reset_i                 (reset_i),
    .conversion_start_input_i(conversion_start_input_i),
    .analog_level_i          (analog_level_i),
    .capture_ready_i         (capture_ready_i),
    .data_o                  (data_o),
    .data_msb_n_o            (data_msb_n_o),
    .out_of_range_flag_o     (out_of_range_flag_o),
    .conversion_done_strobe_o(conversion_done_strobe_o),
    .acquiring_o             (acquiring_o),
    .start_ready_o           (start_ready_o)
);

// file: bench/tb_adcrc_top.sv
`timescale 1ns/1ps
`include "adcrc_defs.svh"

module tb_adcrc_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic stall = 1'b0;
    logic signed [14:0] level = 15'sh0000;
    logic rdy, acq, strobe, msb_n, flag, srdy;
    logic [11:0] data, twos;
    logic [1:0] rng;
    adcrc_pkg::adcrc_result_type new_w, prev_w;
    int cnt, mismatches, cmp_count;
    logic signed [14:0] lv [10] = '{15'sh0000, 15'sh0001, 15'sh0002, 15'sh1000, 15'sh1FFD,
                                    15'sh1FFE, 15'sh1FFF, 15'sh7FFF, 15'sh3FFF, 15'sh4000};
    logic [12:0] ex [10] = '{13'h0000, 13'h0001, 13'h0001, 13'h0800, 13'h0FFF,
                             13'h0FFF, 13'h1FFF, 13'h1000, 13'h1FFF, 13'h1000};

    always #2.5 clk = ~clk;

    adcrc_top #(.CONV_CYCLES(12), .HIGH_CYCLES(4), .LOW_CYCLES(2), .BUF_DEPTH(2)) i_adcrc_top (
        .sys_clk_i(clk), .reset_i(rst), .conversion_start_input_i(start),
        .analog_level_i(level), .capture_ready_i(rdy), .data_o(data), .data_msb_n_o(msb_n),
        .out_of_range_flag_o(flag), .conversion_done_strobe_o(strobe), .acquiring_o(acq),
        .start_ready_o(srdy));
    adcrc_capture_model i_adcrc_capture_model (
        .strobe_i(strobe), .data_i(data), .msb_n_i(msb_n), .flag_i(flag), .stall_i(stall),
        .capture_ready_o(rdy), .new_o(new_w), .prev_o(prev_w), .twos_o(twos), .range_o(rng),
        .count_o(cnt));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task start_conv(input logic signed [14:0] lv_in, input bit wait_rdy);
        for (int n = 0; wait_rdy && n < 300 && srdy !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        level = lv_in;
        start = 1'b1;
        repeat (6) @(negedge clk);
        start = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task wait_cap(input int target);
        for (int n = 0; n < 400 && cnt < target; n++) @(negedge clk);
        check(16'(cnt), 16'(target));
    endtask

    task check_reset;
        check({data, msb_n, flag, strobe, acq}, {12'h000, 4'b1001});
        check(16'(srdy), 16'h0001);
    endtask

    initial begin
        #200000;
        mismatches++;
        test_done;
    end

    initial begin
        repeat (5) @(negedge clk);
        check_reset;
        rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            start_conv(lv[i], 1'b1);
            wait_cap(i + 1);
            check(16'(new_w), 16'(ex[i]));
            check({rng, twos}, {ex[i][12] & ex[i][11], ex[i][12] & ~ex[i][11], ~ex[i][11], ex[i][10:0]});
            if (i > 0) check(16'(prev_w), 16'(ex[i-1]));
            check(16'(acq), 16'h0000);
            repeat (6) @(negedge clk);
            check(16'(acq), 16'h0001);
        end
        repeat (30) @(negedge clk);
        check(16'(flag), 16'h0001);
        start_conv(15'sh0064, 1'b1);
        wait_cap(11);
        check(16'(new_w), 16'h0032);
        stall = 1'b1;
        start_conv(15'sh0002, 1'b1);
        start_conv(15'sh0004, 1'b1);
        start_conv(15'sh0006, 1'b1);
        repeat (40) @(negedge clk);
        check(16'(srdy), 16'h0000);
        start_conv(15'sh0008, 1'b0);
        check(16'(cnt), 16'd11);
        stall = 1'b0;
        for (int k = 0; k < 3; k++) begin
            wait_cap(12 + k);
            check(16'(new_w), 16'(k + 1));
        end
        repeat (200) @(negedge clk);
        check(16'(cnt), 16'd14);
        start_conv(15'sh00C8, 1'b1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check_reset;
        rst = 1'b0;
        start_conv(15'sh0003, 1'b1);
        wait_cap(15);
        check(16'(new_w), 16'h0002);
        test_done;
    end
endmodule

// file: logic/adcrc_buf.sv
`timescale 1ns/1ps

// Small FIFO between the converter core and the pin stage.
module adcrc_buf #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// file: logic/adcrc_defs.svh
`ifndef ADCRC_DEFS_SVH
`define ADCRC_DEFS_SVH

// Clock rate of sys_clk_i in MHz.
`define ADCRC_CLK_MHZ          200
// Time from the start edge to a finished result, in ns.
`define ADCRC_CONV_TIME_NS     800
// High and low widths of the done strobe, in ns.
`define ADCRC_STROBE_HIGH_NS   100
`define ADCRC_STROBE_LOW_NS    50
// Least times round up to whole cycles.
`define ADCRC_CONV_CYCLES      ((`ADCRC_CONV_TIME_NS * `ADCRC_CLK_MHZ + 999) / 1000)
`define ADCRC_HIGH_CYCLES      ((`ADCRC_STROBE_HIGH_NS * `ADCRC_CLK_MHZ + 999) / 1000)
`define ADCRC_LOW_CYCLES       ((`ADCRC_STROBE_LOW_NS * `ADCRC_CLK_MHZ + 999) / 1000)

// Result word and analog level layout.
`define ADCRC_DATA_W           12
`define ADCRC_LEVEL_W          15
// Top of scale in half-code units: centre of code 4095.
`define ADCRC_LEVEL_TOP        15'sh1FFE
`define ADCRC_CODE_MAX         12'hFFF
`define ADCRC_CODE_MIN         12'h000
`define ADCRC_BUF_DEPTH        2

`endif

// file: logic/adcrc_pkg.sv
`include "adcrc_defs.svh"

package adcrc_pkg;

    typedef struct packed {
        logic                       out_of_range;
        logic [`ADCRC_DATA_W-1:0]   code;
    } adcrc_result_type;

    typedef enum logic [1:0] {
        CV_ACQUIRE,
        CV_CONVERT,
        CV_DELIVER
    } adcrc_conv_state_type;

    typedef enum logic [1:0] {
        OS_IDLE,
        OS_SETUP,
        OS_HIGH,
        OS_LOW
    } adcrc_out_state_type;

endpackage

// file: logic/adcrc_top.sv
`timescale 1ns/1ps
`include "adcrc_defs.svh"

module adcrc_top #(
    parameter int CONV_CYCLES = `ADCRC_CONV_CYCLES,
    parameter int HIGH_CYCLES = `ADCRC_HIGH_CYCLES,
    parameter int LOW_CYCLES  = `ADCRC_LOW_CYCLES,
    parameter int BUF_DEPTH   = `ADCRC_BUF_DEPTH
) (
    // Clock and reset
    input  wire logic                              sys_clk_i,
    input  wire logic                              reset_i,
    // Conversion control pin and analog level in half-code units
    input  wire logic                              conversion_start_input_i,
    input  wire logic signed [`ADCRC_LEVEL_W-1:0]  analog_level_i,
    // Receiver readiness to capture a new word
    input  wire logic                              capture_ready_i,
    // Result pins
    output logic [`ADCRC_DATA_W-1:0]               data_o,
    output logic                                   data_msb_n_o,
    output logic                                   out_of_range_flag_o,
    output logic                                   conversion_done_strobe_o,
    // Status
    output logic                                   acquiring_o,
    output logic                                   start_ready_o
);
    localparam int RES_W = $bits(adcrc_pkg::adcrc_result_type);

    // Turn a held level into a saturated code and its range flag.
    function automatic adcrc_pkg::adcrc_result_type quantize(
        input logic signed [`ADCRC_LEVEL_W-1:0] level
    );
        adcrc_pkg::adcrc_result_type res;
        logic signed [`ADCRC_LEVEL_W:0]         rounded;
        rounded = ($signed({level[`ADCRC_LEVEL_W-1], level}) + 16'sh0001) >>> 1;
        res     = '0;
        if (level < 15'sh0000) begin
            res.out_of_range = (level <= -15'sh0001);
            res.code         = `ADCRC_CODE_MIN;
        end else if (level > `ADCRC_LEVEL_TOP) begin
            res.out_of_range = (level >= `ADCRC_LEVEL_TOP + 15'sh0001);
            res.code         = `ADCRC_CODE_MAX;
        end else begin
            res.out_of_range = 1'b0;
            res.code         = rounded[`ADCRC_DATA_W-1:0];
        end
        return res;
    endfunction

    // Start pin synchroniser.
    logic start_s1_r;
    logic start_s2_r;
    logic start_s3_r;
    logic start_level_r;
    logic start_edge;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_s3_r <= 1'b0;
        end else begin
            start_s1_r <= conversion_start_input_i;
            start_s2_r <= start_s1_r;
            start_s3_r <= start_s2_r;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_level_r <= 1'b0;
        end else if (start_s2_r == start_s3_r) begin
            start_level_r <= start_s3_r;
        end
    end

    assign start_edge = (start_s2_r == start_s3_r) && start_s3_r && !start_level_r;

    // Converter core.
    adcrc_pkg::adcrc_conv_state_type conv_state_r;
    logic [15:0]                     conv_cnt_r;
    logic signed [`ADCRC_LEVEL_W-1:0] held_level_r;
    adcrc_pkg::adcrc_result_type     result_r;
    logic                            buf_in_ready;
    logic                            buf_out_valid;
    logic                            buf_out_ready;
    logic [RES_W-1:0]                buf_out_data;

    assign start_ready_o = (conv_state_r == adcrc_pkg::CV_ACQUIRE);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_state_r <= adcrc_pkg::CV_ACQUIRE;
            conv_cnt_r   <= '0;
            held_level_r <= '0;
            result_r     <= '0;
        end else begin
            unique case (conv_state_r)
                adcrc_pkg::CV_ACQUIRE: begin
                    if (start_edge) begin
                        held_level_r <= analog_level_i;
                        conv_cnt_r   <= 16'(CONV_CYCLES - 1);
                        conv_state_r <= adcrc_pkg::CV_CONVERT;
                    end
                end
                adcrc_pkg::CV_CONVERT: begin
                    if (conv_cnt_r == '0) begin
                        result_r     <= quantize(held_level_r);
                        conv_state_r <= adcrc_pkg::CV_DELIVER;
                    end else begin
                        conv_cnt_r <= conv_cnt_r - 1'b1;
                    end
                end
                adcrc_pkg::CV_DELIVER: begin
                    if (buf_in_ready) begin
                        conv_state_r <= adcrc_pkg::CV_ACQUIRE;
                    end
                end
            endcase
        end
    end

    adcrc_buf #(
        .WIDTH (RES_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (conv_state_r == adcrc_pkg::CV_DELIVER),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (result_r),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    // Pin stage: data settles one cycle before the strobe rises.
    adcrc_pkg::adcrc_out_state_type out_state_r;
    logic [15:0]                    out_cnt_r;
    adcrc_pkg::adcrc_result_type    pin_word;

    assign pin_word      = buf_out_data;
    assign buf_out_ready = (out_state_r == adcrc_pkg::OS_IDLE) && capture_ready_i;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_state_r <= adcrc_pkg::OS_IDLE;
            out_cnt_r   <= '0;
        end else begin
            unique case (out_state_r)
                adcrc_pkg::OS_IDLE: begin
                    if (buf_out_valid && capture_ready_i) begin
                        out_state_r <= adcrc_pkg::OS_SETUP;
                    end
                end
                adcrc_pkg::OS_SETUP: begin
                    out_cnt_r   <= 16'(HIGH_CYCLES - 1);
                    out_state_r <= adcrc_pkg::OS_HIGH;
                end
                adcrc_pkg::OS_HIGH: begin
                    if (out_cnt_r == '0) begin
                        out_cnt_r   <= 16'(LOW_CYCLES - 1);
                        out_state_r <= adcrc_pkg::OS_LOW;
                    end else begin
                        out_cnt_r <= out_cnt_r - 1'b1;
                    end
                end
                adcrc_pkg::OS_LOW: begin
                    if (out_cnt_r == '0) begin
                        out_state_r <= adcrc_pkg::OS_IDLE;
                    end else begin
                        out_cnt_r <= out_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Data and flag change together and only when a finished result is shown.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            data_o              <= '0;
            data_msb_n_o        <= 1'b1;
            out_of_range_flag_o <= 1'b0;
        end else if (buf_out_ready && buf_out_valid) begin
            data_o              <= pin_word.code;
            data_msb_n_o        <= ~pin_word.code[`ADCRC_DATA_W-1];
            out_of_range_flag_o <= pin_word.out_of_range;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_done_strobe_o <= 1'b0;
        end else begin
            conversion_done_strobe_o <= (out_state_r == adcrc_pkg::OS_SETUP) ||
                                        ((out_state_r == adcrc_pkg::OS_HIGH) &&
                                         (out_cnt_r != '0));
        end
    end

    // The sampler holds from a start until the strobe of a result falls.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acquiring_o <= 1'b1;
        end else if (start_edge && conv_state_r == adcrc_pkg::CV_ACQUIRE) begin
            acquiring_o <= 1'b0;
        end else if (out_state_r == adcrc_pkg::OS_LOW &&
                     out_cnt_r == 16'(LOW_CYCLES - 1) &&
                     conv_state_r != adcrc_pkg::CV_CONVERT) begin
            // First low cycle after the strobe fell; a running conversion keeps holding.
            acquiring_o <= 1'b1;
        end
    end

endmodule
